//--- hw/fatc_acq_ctrl.sv
// Notes on behaviour
// - Continuous, multi, single modes; continuous after reset
// - Multi mode: programmed count, then stop
// - Single mode: one frame, then stop
// - Begin and end commands follow selected mode
// - Rate override paces frames at target rate
// - Report achieved rate, lower when exposure long
// - Timed exposure default, or trigger pulse width
// - Timed manual exposure lasts programmed microseconds
// - One-shot auto returns to off; continuous stays
// - Triggers honoured only while gating enabled
// - Acquisition-start trigger runs sequence in mode
// - Frame-start single/multi needs begin before retrigger
// - Frame-start continuous: one frame per trigger
// - Burst trigger: burst, multi count or one
// - Source select: line, user, counter, logic, software
// - Activation: low, high, falling, rising, any edge
// - Overlap off ignores triggers during readout
// - Wait trigger delay microseconds before exposure
// - Each software command is one trigger
`timescale 1ns/1ps
`default_nettype none
module fatc_acq_ctrl
  import fatc_pkg::*;
#(
  parameter int MEASURE_CYCLES = MEASURE_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire fatc_cfg_s cfg,
  input wire logic begin_capture_cmd,
  input wire logic end_capture_cmd,
  input wire logic soft_trigger_cmd,
  input wire logic auto_exposure_wr,
  input wire fatc_auto_e auto_exposure_wdata,
  input wire logic [EXPO_W-1:0] ae_exposure_us,
  input wire fatc_trig_src_s trig_src,
  input wire logic readout_busy,
  output logic exposure_active,
  output logic frame_start_pulse,
  output logic acquisition_active,
  output fatc_auto_e auto_exposure_setting,
  output logic [RATE_W-1:0] achieved_frame_rate
);
  fatc_state_e state;
  fatc_state_e next_state;
  logic trig_event;
  logic trig_level;
  logic trig_ok;
  logic readout_clear;
  logic trig_run;
  logic endless;
  logic [CNT_W-1:0] frames_left;
  logic [CNT_W-1:0] seq_count;
  logic last_frame;
  logic rearm;
  logic pulse_mode;
  logic expo_end;
  logic delay_start;
  logic delay_done;
  logic expo_start;
  logic expo_done;
  logic [EXPO_W-1:0] expo_us;
  logic pace_ok;
  logic pace_tick;
  logic [PACE_W-1:0] pace_acc;
  logic [PACE_W-1:0] pace_sum;
  logic [31:0] win_cnt;
  logic [RATE_W-1:0] frame_cnt;
  logic [ONCE_W-1:0] once_cnt;

  fatc_trig_qual u_qual (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src(trig_src),
    .soft_trigger_cmd(soft_trigger_cmd),
    .sel(cfg.trigger_origin_select),
    .pol(cfg.trigger_polarity_select),
    .trig_event(trig_event),
    .trig_level(trig_level)
  );

  fatc_us_timer #(.W(DLY_W)) u_delay (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(delay_start),
    .us_val(cfg.trigger_to_exposure_delay),
    .done(delay_done)
  );

  fatc_us_timer #(.W(EXPO_W)) u_expo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(expo_start),
    .us_val(expo_us),
    .done(expo_done)
  );

  assign readout_clear = !readout_busy || (cfg.readout_overlap_select == ov_readout);
  assign trig_ok = trig_event && cfg.trigger_gate_enable && readout_clear;
  assign last_frame = !endless && (frames_left <= CNT_W'(1));
  // Which triggered sequences stay armed once their frames are done
  assign rearm = trig_run && (cfg.trigger_type_select != tt_acq_start) &&
                 ((cfg.trigger_type_select == tt_burst_start) ||
                  (cfg.capture_mode_select == cap_continuous));
  assign expo_end = pulse_mode ? !trig_level : expo_done;
  // Manual value only when auto exposure is off; otherwise the adapted value
  assign expo_us = (auto_exposure_setting == ae_off) ? cfg.exposure_duration_us
                                                      : ae_exposure_us;
  assign delay_start = (state == st_wait_trig) && trig_ok && !end_capture_cmd;
  assign expo_start = (next_state == st_expose) && (state != st_expose);

  // Zero counts are taken as one so a sequence always ends
  always_comb begin
    seq_count = CNT_W'(1);
    if (cfg.capture_mode_select == cap_multi) begin
      if (cfg.multi_capture_count != '0) begin
        seq_count = cfg.multi_capture_count;
      end
    end else if (cfg.capture_mode_select == cap_continuous &&
                 cfg.trigger_type_select == tt_burst_start) begin
      if (cfg.burst_count != '0) begin
        seq_count = cfg.burst_count;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (begin_capture_cmd) begin
          next_state = cfg.trigger_gate_enable ? st_wait_trig : st_pace;
        end
      end
      st_wait_trig: begin
        if (trig_ok) begin
          next_state = st_delay;
        end
      end
      st_pace: begin
        if (pace_ok && readout_clear) begin
          next_state = st_expose;
        end
      end
      st_delay: begin
        if (delay_done) begin
          next_state = st_expose;
        end
      end
      st_expose: begin
        if (expo_end) begin
          if (!last_frame) begin
            next_state = st_pace;
          end else if (rearm) begin
            next_state = st_wait_trig;
          end else begin
            next_state = st_idle;
          end
        end
      end
      default: next_state = st_idle;
    endcase
    if (end_capture_cmd) begin
      next_state = st_idle;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      exposure_active <= 1'h0;
      frame_start_pulse <= 1'h0;
      acquisition_active <= 1'h0;
    end else begin
      state <= next_state;
      exposure_active <= (next_state == st_expose);
      frame_start_pulse <= expo_start;
      acquisition_active <= (next_state != st_idle);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frames_left <= '0;
      endless <= 1'h0;
      trig_run <= 1'h0;
    end else if (end_capture_cmd) begin
      frames_left <= '0;
      endless <= 1'h0;
      trig_run <= 1'h0;
    end else if (state == st_idle && begin_capture_cmd) begin
      trig_run <= cfg.trigger_gate_enable;
      frames_left <= seq_count;
      endless <= (cfg.capture_mode_select == cap_continuous);
    end else if (delay_start) begin
      frames_left <= seq_count;
      endless <= (cfg.capture_mode_select == cap_continuous) &&
                 (cfg.trigger_type_select == tt_acq_start);
    end else if (state == st_expose && expo_end && !endless) begin
      frames_left <= frames_left - CNT_W'(1);
    end
  end

  // Pulse width governs only exposures that a trigger launched
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_mode <= 1'h0;
    end else if (expo_start) begin
      pulse_mode <= (state == st_delay) &&
                    (cfg.exposure_mode_select == expo_pulse_width);
    end
  end

  assign pace_sum = pace_acc + PACE_W'(cfg.target_frame_rate);
  assign pace_tick = (pace_sum >= PACE_WRAP);

  // Credit from the rate tick wins over its use in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_acc <= '0;
      pace_ok <= 1'h1;
    end else if (!cfg.rate_override_enable) begin
      pace_acc <= '0;
      pace_ok <= 1'h1;
    end else begin
      pace_acc <= pace_tick ? (pace_sum - PACE_WRAP) : pace_sum;
      if (pace_tick) begin
        pace_ok <= 1'h1;
      end else if (state == st_pace && expo_start) begin
        pace_ok <= 1'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt <= '0;
      frame_cnt <= '0;
      achieved_frame_rate <= '0;
    end else if (win_cnt == 32'(MEASURE_CYCLES - 1)) begin
      win_cnt <= '0;
      frame_cnt <= '0;
      achieved_frame_rate <= frame_cnt + RATE_W'(frame_start_pulse);
    end else begin
      win_cnt <= win_cnt + 32'h1;
      frame_cnt <= frame_cnt + RATE_W'(frame_start_pulse);
    end
  end

  // A software write wins over the automatic return to off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_exposure_setting <= AE_RESET;
      once_cnt <= '0;
    end else if (auto_exposure_wr) begin
      auto_exposure_setting <= auto_exposure_wdata;
      once_cnt <= '0;
    end else if (auto_exposure_setting == ae_once && state == st_expose && expo_end) begin
      if (once_cnt == AE_ONCE_LAST) begin
        auto_exposure_setting <= ae_off;
        once_cnt <= '0;
      end else begin
        once_cnt <= once_cnt + ONCE_W'(1);
      end
    end
  end

  // Checking helpers: cycles spent in the current state and its due length
  logic [CHK_W-1:0] chk_cnt;
  logic [CHK_W-1:0] chk_due;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_cnt <= '0;
      chk_due <= '0;
    end else begin
      chk_cnt <= (next_state != state) ? '0 : chk_cnt + CHK_W'(1);
      if (delay_start) begin
        chk_due <= CHK_W'(cfg.trigger_to_exposure_delay) * CHK_W'(CYC_PER_US);
      end else if (expo_start) begin
        chk_due <= CHK_W'(expo_us) * CHK_W'(CYC_PER_US);
      end
    end
  end

  property p_end_idle;
    @(posedge ref_clk) disable iff (!rst_n)
    end_capture_cmd |=> (state == st_idle) && !exposure_active && (frames_left == '0);
  endproperty
  a_end_idle: assert property (p_end_idle) else $error("end command did not idle");

  property p_seq_done;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == st_expose && expo_end && last_frame && !trig_run && !end_capture_cmd)
      |=> (state == st_idle) && !acquisition_active;
  endproperty
  a_seq_done: assert property (p_seq_done) else $error("sequence did not end");

  property p_gate_off;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == st_idle && begin_capture_cmd && !end_capture_cmd && !cfg.trigger_gate_enable)
      |=> (state == st_pace);
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("free run not entered");

  property p_no_overlap;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == st_wait_trig && readout_busy && cfg.readout_overlap_select == ov_off)
      |=> (state != st_delay);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("trigger taken in readout");

  property p_delay_len;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == st_delay && next_state == st_expose)
      |-> (chk_cnt + CHK_W'(1) == ((chk_due == '0) ? CHK_W'(1) : chk_due));
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("trigger delay wrong");

  property p_expo_len;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == st_expose && !pulse_mode && expo_end && !end_capture_cmd)
      |-> (chk_cnt + CHK_W'(1) == ((chk_due == '0) ? CHK_W'(1) : chk_due));
  endproperty
  a_expo_len: assert property (p_expo_len) else $error("timed exposure wrong");

  property p_pulse_end;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == st_expose && pulse_mode && !trig_level) |=> !exposure_active;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse exposure overran");

  property p_once_off;
    @(posedge ref_clk) disable iff (!rst_n)
    (auto_exposure_setting == ae_once && once_cnt == AE_ONCE_LAST && state == st_expose &&
     expo_end && !auto_exposure_wr) |=> (auto_exposure_setting == ae_off);
  endproperty
  a_once_off: assert property (p_once_off) else $error("one-shot did not end");

  property p_frame_rearm;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == st_expose && expo_end && trig_run && last_frame && !end_capture_cmd &&
     cfg.trigger_type_select == tt_frame_start && cfg.capture_mode_select == cap_continuous)
      |=> (state == st_wait_trig) ##1 (state != st_expose);
  endproperty
  a_frame_rearm: assert property (p_frame_rearm) else $error("frame start not rearmed");

  property p_pace_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == st_pace && cfg.rate_override_enable && !pace_ok) |=> !frame_start_pulse;
  endproperty
  a_pace_hold: assert property (p_pace_hold) else $error("frame started unpaced");

  c_single: cover property (@(posedge ref_clk) disable iff (!rst_n)
    (cfg.capture_mode_select == cap_single && frame_start_pulse) ##[1:1000] (state == st_idle));
  c_trigger: cover property (@(posedge ref_clk) disable iff (!rst_n) delay_start);
  c_burst: cover property (@(posedge ref_clk) disable iff (!rst_n)
    (cfg.trigger_type_select == tt_burst_start && rearm && state == st_wait_trig));
  c_once: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(auto_exposure_setting) && (auto_exposure_setting == ae_off));
endmodule : fatc_acq_ctrl
`default_nettype wire

//--- hw/fatc_trig_qual.sv
`timescale 1ns/1ps
`default_nettype none
module fatc_trig_qual
  import fatc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire fatc_trig_src_s src,
  input wire logic soft_trigger_cmd,
  input wire logic [SRC_W-1:0] sel,
  input wire fatc_polarity_e pol,
  output logic trig_event,
  output logic trig_level
);
  logic [15:0] src_vec;
  logic bit_now;
  logic bit_prev;

  always_comb begin
    src_vec = '0;
    src_vec[SRC_LINE0 +: 4] = src.line_in;
    src_vec[SRC_USER0 +: 4] = src.user_out;
    src_vec[SRC_CNT0 +: 2] = src.counter_out;
    src_vec[SRC_LOGIC0 +: 2] = src.logic_out;
    src_vec[SRC_SOFT] = soft_trigger_cmd;
  end

  assign bit_now = src_vec[sel];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_prev <= 1'h0;
    end else begin
      bit_prev <= bit_now;
    end
  end

  // A software command is one event whatever the activation
  always_comb begin
    trig_event = 1'h0;
    trig_level = 1'h0;
    if (sel == SRC_SOFT) begin
      trig_event = soft_trigger_cmd;
      trig_level = soft_trigger_cmd;
    end else begin
      case (pol)
        pol_low: begin
          trig_event = !bit_now;
          trig_level = !bit_now;
        end
        pol_high: begin
          trig_event = bit_now;
          trig_level = bit_now;
        end
        pol_fall: begin
          trig_event = bit_prev && !bit_now;
          trig_level = !bit_now;
        end
        pol_rise: begin
          trig_event = !bit_prev && bit_now;
          trig_level = bit_now;
        end
        pol_any: begin
          trig_event = bit_prev ^ bit_now;
          trig_level = 1'h1;
        end
        default: begin
          trig_event = 1'h0;
          trig_level = 1'h0;
        end
      endcase
    end
  end
endmodule : fatc_trig_qual
`default_nettype wire

//--- hw/fatc_us_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fatc_us_timer
  import fatc_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [W-1:0] us_val,
  output logic done
);
  logic [W-1:0] us_left;
  logic [CYC_W-1:0] cyc;
  logic running;

  // A zero load still expires one cycle after the start
  assign done = running && (us_left == '0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      us_left <= '0;
      cyc <= '0;
      running <= 1'h0;
    end else if (start) begin
      // First microsecond is one cycle short: done then closes exactly us_val*100 cycles
      us_left <= us_val;
      cyc <= CYC_LAST - CYC_W'(1);
      running <= 1'h1;
    end else if (running) begin
      if (done) begin
        running <= 1'h0;
      end else if (cyc == '0) begin
        cyc <= CYC_LAST;
        us_left <= us_left - W'(1);
      end else begin
        cyc <= cyc - CYC_W'(1);
      end
    end
  end
endmodule : fatc_us_timer
`default_nettype wire

//--- include/fatc_pkg.sv
`default_nettype none
package fatc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int CYC_W = 7;
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CYC_PER_US - 1);

  localparam int CNT_W = 16;
  localparam int RATE_W = 16;
  localparam int EXPO_W = 24;
  localparam int DLY_W = 16;
  localparam int SRC_W = 4;
  localparam int CHK_W = 32;

  // Rate pacing is a phase accumulator wrapping at the clock rate in Hz
  localparam int PACE_W = 28;
  localparam logic [PACE_W-1:0] PACE_WRAP = PACE_W'(CLK_HZ);

  // Achieved rate is counted over a one second window
  localparam int MEASURE_MS = 1000;
  localparam int MEASURE_CYCLES_DEF = MEASURE_MS * (CLK_HZ / 1000);

  // Frames of adaptation before one-shot auto exposure falls back to off
  localparam int ONCE_W = 3;
  localparam logic [ONCE_W-1:0] AE_ONCE_LAST = 3'h3;

  // Trigger origin codes
  localparam logic [SRC_W-1:0] SRC_LINE0 = 4'h0;
  localparam logic [SRC_W-1:0] SRC_USER0 = 4'h4;
  localparam logic [SRC_W-1:0] SRC_CNT0 = 4'h8;
  localparam logic [SRC_W-1:0] SRC_LOGIC0 = 4'hA;
  localparam logic [SRC_W-1:0] SRC_SOFT = 4'hF;

  typedef enum logic [1:0] {cap_continuous, cap_multi, cap_single} fatc_capture_e;
  typedef enum logic {expo_timed, expo_pulse_width} fatc_expo_e;
  typedef enum logic [1:0] {ae_continuous, ae_once, ae_off} fatc_auto_e;
  typedef enum logic [1:0] {tt_acq_start, tt_frame_start, tt_burst_start} fatc_trig_type_e;
  typedef enum logic [2:0] {pol_low, pol_high, pol_fall, pol_rise, pol_any} fatc_polarity_e;
  typedef enum logic {ov_off, ov_readout} fatc_overlap_e;
  typedef enum logic [2:0] {st_idle, st_wait_trig, st_pace, st_delay, st_expose} fatc_state_e;

  localparam fatc_auto_e AE_RESET = ae_continuous;

  typedef struct packed {
    fatc_capture_e capture_mode_select;
    logic [CNT_W-1:0] multi_capture_count;
    logic [CNT_W-1:0] burst_count;
    logic rate_override_enable;
    logic [RATE_W-1:0] target_frame_rate;
    fatc_expo_e exposure_mode_select;
    logic [EXPO_W-1:0] exposure_duration_us;
    logic trigger_gate_enable;
    fatc_trig_type_e trigger_type_select;
    logic [SRC_W-1:0] trigger_origin_select;
    fatc_polarity_e trigger_polarity_select;
    fatc_overlap_e readout_overlap_select;
    logic [DLY_W-1:0] trigger_to_exposure_delay;
  } fatc_cfg_s;

  typedef struct packed {
    logic [3:0] line_in;
    logic [3:0] user_out;
    logic [1:0] counter_out;
    logic [1:0] logic_out;
  } fatc_trig_src_s;
endpackage : fatc_pkg
`default_nettype wire

//--- tb/fatc_acq_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %0d seen %0d", nm, e, a); end end
module fatc_acq_ctrl_bench;
  import fatc_pkg::*;
  localparam int MC = 10000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  fatc_cfg_s cfg = '0;
  fatc_trig_src_s trig_src = '0;
  logic begin_capture_cmd = 1'b0;
  logic end_capture_cmd = 1'b0;
  logic soft_trigger_cmd = 1'b0;
  logic auto_exposure_wr = 1'b0;
  fatc_auto_e auto_exposure_wdata = ae_continuous;
  logic [EXPO_W-1:0] ae_exposure_us = 24'h000002;
  logic readout_busy, exposure_active, frame_start_pulse, acquisition_active;
  fatc_auto_e auto_exposure_setting;
  logic [RATE_W-1:0] achieved_frame_rate;
  logic strict = 1'b1;
  logic was_exp = 1'b0;
  int cyc = 0, mismatches = 0, check_count = 0, nfr = 0, run = 0, cur_len = -1;
  int q_st[$], q_len[$];
  int tv[7] = '{0, 0, 1, 1, 2, 2, 2};
  int mv[7] = '{1, 2, 2, 1, 0, 1, 2};
  int fv[7] = '{2, 1, 1, 2, 3, 2, 1};

  fatc_acq_ctrl #(.MEASURE_CYCLES(MC)) fatc_acq_ctrl_i (.ref_clk, .rst_n, .cfg,
    .begin_capture_cmd, .end_capture_cmd, .soft_trigger_cmd, .auto_exposure_wr,
    .auto_exposure_wdata, .ae_exposure_us, .trig_src, .readout_busy, .exposure_active,
    .frame_start_pulse, .acquisition_active, .auto_exposure_setting, .achieved_frame_rate);
  fatc_sensor_model fatc_sensor_model_i (.ref_clk, .rst_n, .exposure_active, .readout_busy);

  always #5 ref_clk = ~ref_clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // Each frame start takes the oldest note; start -1 or length -1 is not compared
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    was_exp <= exposure_active;
    if (cyc == 95000) begin
      mismatches++;
      end_of_test();
    end
    if (frame_start_pulse === 1'b1) begin
      nfr <= nfr + 1;
      run <= 1;
      cur_len = -1;
      if (q_st.size() == 0) begin
        if (strict) `CHK("unexpected frame", 0, 1)
      end else begin
        cur_len = q_len.pop_front();
        if (q_st[0] >= 0) `CHK("frame start cycle", q_st[0], cyc)
        void'(q_st.pop_front());
      end
    end else if (exposure_active === 1'b1) run <= run + 1;
    else if (was_exp && cur_len >= 0) begin
      `CHK("exposure cycles", cur_len, run)
      cur_len = -1;
    end
  end

  function automatic int st(int d);
    return cyc + 2 + ((d > 0) ? d * 100 : 1);
  endfunction : st

  function automatic int bitof(int c);
    return (c < 4) ? 8 + c : (c < 8) ? c : (c < 10) ? c - 6 : c - 10;
  endfunction : bitof

  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic note(int s, int n, int l);
    for (int i = 0; i < n; i++) begin
      q_st.push_back((i == 0) ? s : -1);
      q_len.push_back(l);
    end
  endtask : note

  // One-cycle command: 0 begin, 1 end, 2 software trigger
  task automatic cmd(int w, int n, int d, int l);
    tick();
    note(st(d), n, l);
    begin_capture_cmd <= (w == 0);
    end_capture_cmd <= (w == 1);
    soft_trigger_cmd <= (w == 2);
    tick();
    {begin_capture_cmd, end_capture_cmd, soft_trigger_cmd} <= 3'h0;
  endtask : cmd

  task automatic pin(int c, logic v, int n, int d, int l);
    tick();
    note(st(d), n, l);
    trig_src[bitof(c)] <= v;
  endtask : pin

  task automatic settle();
    for (int t = 0; t < 3000 && (q_st.size() != 0 || exposure_active !== 1'b0); t++) tick();
    tick(60);
    `CHK("frames missing", 0, q_st.size())
  endtask : settle

  initial begin
    int e;
    int d;
    logic [SRC_W-1:0] srcs[5] = '{SRC_LINE0, SRC_USER0 + 4'h1, SRC_CNT0 + 4'h1,
                                  SRC_LOGIC0, SRC_SOFT};
    fatc_polarity_e pv[4] = '{pol_rise, pol_fall, pol_any, pol_any};
    void'($urandom(32'hD763));
    e = $urandom_range(3, 1);
    tick(2);
    `CHK("auto setting at reset", ae_continuous, auto_exposure_setting)
    `CHK("idle at reset", 1'b0, acquisition_active)
    rst_n <= 1'b1;
    // All-zero settings: continuous, untriggered, auto exposure continuous
    cmd(0, 1, 0, 200);
    note(-1, 1, -1);
    for (int t = 0; t < 1000 && nfr < 2; t++) tick();
    cmd(1, 0, 0, 0);
    settle();
    `CHK("stopped", 1'b0, acquisition_active)
    tick();
    auto_exposure_wr <= 1'b1;
    auto_exposure_wdata <= ae_once;
    cfg.capture_mode_select <= cap_multi;
    cfg.multi_capture_count <= 16'h0006;
    cfg.exposure_duration_us <= EXPO_W'(e);
    tick();
    auto_exposure_wr <= 1'b0;
    cmd(0, 4, 0, 200);
    note(-1, 2, e * 100);
    settle();
    `CHK("one-shot back to off", ae_off, auto_exposure_setting)
    cfg.capture_mode_select <= cap_single;
    cmd(0, 1, 0, e * 100);
    settle();
    `CHK("single ends", 1'b0, acquisition_active)
    cfg.capture_mode_select <= cap_continuous;
    cfg.trigger_gate_enable <= 1'b1;
    cfg.trigger_type_select <= tt_frame_start;
    cfg.trigger_polarity_select <= pol_rise;
    cmd(0, 0, 0, 0);
    foreach (srcs[i]) begin
      d = $urandom_range(2);
      cfg.trigger_origin_select <= srcs[i];
      cfg.trigger_to_exposure_delay <= DLY_W'(d);
      if (srcs[i] == SRC_SOFT) cmd(2, 1, d, e * 100);
      else begin
        pin(srcs[i], 1'b1, 1, d, e * 100);
        settle();
        pin(srcs[i], 1'b0, 0, 0, 0);
      end
      settle();
    end
    cfg.trigger_origin_select <= SRC_LINE0;
    cfg.trigger_to_exposure_delay <= '0;
    foreach (pv[i]) begin
      cfg.trigger_polarity_select <= pv[i];
      pin(0, i % 2 == 0, 1, 0, e * 100);
      settle();
    end
    // Timed exposure is at least 100 cycles, so an early end shows pulse width
    cfg.exposure_mode_select <= expo_pulse_width;
    cfg.trigger_polarity_select <= pol_high;
    pin(0, 1'b1, 1, 0, -1);
    tick(30);
    `CHK("exposing while active", 1'b1, exposure_active)
    pin(0, 1'b0, 0, 0, 0);
    tick(10);
    `CHK("exposure ends with trigger", 1'b0, exposure_active)
    settle();
    cfg.exposure_mode_select <= expo_timed;
    cfg.trigger_origin_select <= SRC_SOFT;
    for (int ov = 0; ov < 2; ov++) begin
      cfg.readout_overlap_select <= fatc_overlap_e'(ov);
      cmd(2, 1, 0, e * 100);
      for (int t = 0; t < 1000 && readout_busy !== 1'b1; t++) tick();
      cmd(2, ov, 0, e * 100);
      settle();
    end
    cfg.multi_capture_count <= 16'h0002;
    cfg.burst_count <= 16'h0003;
    for (int i = 0; i < 7; i++) begin
      cfg.trigger_type_select <= fatc_trig_type_e'(tv[i]);
      cfg.capture_mode_select <= fatc_capture_e'(mv[i]);
      cmd(1, 0, 0, 0);
      cmd(0, 0, 0, 0);
      cmd(2, fv[i], 0, e * 100);
      settle();
      cmd(2, (tv[i] == 2) ? fv[i] : 0, 0, e * 100);
      settle();
    end
    cmd(1, 0, 0, 0);
    strict <= 1'b0;
    cfg.trigger_gate_enable <= 1'b0;
    cfg.capture_mode_select <= cap_continuous;
    cfg.rate_override_enable <= 1'b1;
    cfg.target_frame_rate <= 16'hC350;
    cfg.exposure_duration_us <= 24'h000001;
    cmd(0, 0, 0, 0);
    tick(22000);
    `CHK("paced rate", MC / 2000, achieved_frame_rate)
    cfg.exposure_duration_us <= 24'h00001E;
    tick(22000);
    `CHK("rate below target", 1'b1, achieved_frame_rate < 16'h0005)
    cmd(1, 0, 0, 0);
    end_of_test();
  end
endmodule : fatc_acq_ctrl_bench
`default_nettype wire

//--- tb/fatc_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module fatc_sensor_model #(
  parameter int READ_CYC = 40
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic exposure_active,
  output logic readout_busy
);
  logic was_exp;
  int left;
  // Readout of a frame starts one cycle after its exposure ends
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      was_exp <= 1'b0;
      left <= 0;
    end else begin
      was_exp <= exposure_active;
      if (was_exp && !exposure_active) left <= READ_CYC;
      else if (left > 0) left <= left - 1;
    end
  end
  assign readout_busy = (left > 0);
endmodule : fatc_sensor_model
`default_nettype wire
